//--- src/ssa_pkg.sv
// constants and types for the serial step attenuator control block
// assumes one reference clock domain; all link pins are sampled by it
`default_nettype none

package ssa_pkg;

  // frame layout
  localparam int unsigned FRAME_BITS  = 16;
  localparam int unsigned CNT_W       = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam int unsigned DATA_LSB    = 0;
  localparam int unsigned DATA_MSB    = 7;
  localparam int unsigned CHIP_LSB    = 8;
  localparam int unsigned CHIP_MSB    = 10;
  localparam int unsigned REG_LSB     = 12;
  localparam int unsigned REG_MSB     = 15;

  // chip address of this device is fixed
  localparam logic [2:0] CHIP_ADDR    = 3'h0;

  // register addresses
  localparam logic [3:0] ADDR_PRIMARY = 4'h0;
  localparam logic [3:0] ADDR_SETUP   = 4'h1;
  localparam logic [3:0] ADDR_FAST    = 4'h2;

  // attenuation word: 7 bits of 0.25 dB cells
  localparam int unsigned ATT_W       = 7;
  localparam int unsigned REG_W       = 8;
  localparam logic [REG_W-1:0] PRIMARY_RST = 8'h7F;
  localparam logic [REG_W-1:0] SETUP_RST   = 8'h00;
  localparam logic [REG_W-1:0] FAST_RST    = 8'h7F;
  localparam logic [ATT_W-1:0] ATT_MAX     = 7'h7F;

  // setup register fields
  localparam int unsigned SETUP_PTR_BIT = 0;
  localparam int unsigned SETUP_EN_BIT  = 1;

  // synchroniser lane order and reset levels (strobe idles high)
  localparam int unsigned SYNC_W      = 4;
  localparam int unsigned LANE_CLK    = 0;
  localparam int unsigned LANE_DATA   = 1;
  localparam int unsigned LANE_STROBE = 2;
  localparam int unsigned LANE_FAST   = 3;
  localparam logic [SYNC_W-1:0] SYNC_RST = 4'h4;

  // link sequencer states
  typedef enum logic [1:0] {
    SSA_IDLE,
    SSA_SHIFT,
    SSA_ARMED
  } ssa_state_e;

endpackage : ssa_pkg

`default_nettype wire

//--- src/ssa_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to i_clk; reset already synchronised
`default_nettype none

module ssa_sync (
  input  wire logic                      i_clk,    // reference clock
  input  wire logic                      i_rst_n,  // synchronised reset, active low
  input  wire logic [ssa_pkg::SYNC_W-1:0] i_pins,  // raw pin levels
  output var  logic [ssa_pkg::SYNC_W-1:0] o_level  // filtered levels
);
  import ssa_pkg::*;

  logic [SYNC_W-1:0] stage1;
  logic [SYNC_W-1:0] stage2;
  logic [SYNC_W-1:0] stage3;
  wire  [SYNC_W-1:0] agree;

  // stage1 feeds stage2 only, to keep metastability contained
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= SYNC_RST;
      stage2 <= SYNC_RST;
      stage3 <= SYNC_RST;
    end else begin
      stage1 <= i_pins;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // per lane: a change counts once stage2 and stage3 agree
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_lane
      assign agree[g] = ~(stage2[g] ^ stage3[g]);
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_level[g] <= SYNC_RST[g];
        end else if (agree[g]) begin
          o_level[g] <= stage3[g];
        end
      end
    end
  endgenerate

endmodule : ssa_sync

`default_nettype wire

//--- src/ssa_top.sv
// serial write-only control of the step attenuator
// assumes serial clock, data, strobe and fast-select pin are asynchronous
// pins; the serial clock must be well below a quarter of the 20 MHz clock
`default_nettype none

module ssa_top (
  input  wire logic                     i_ref_clk,        // 20 MHz reference clock
  input  wire logic                     i_nrst,           // power-on reset, active low
  input  wire logic                     i_ser_clk,        // serial clock pin
  input  wire logic                     i_ser_data,       // serial data pin
  input  wire logic                     i_latch_strobe,   // latch strobe pin
  input  wire logic                     i_fast_select_pin, // fast-select pin
  output var  logic [ssa_pkg::ATT_W-1:0] o_atten_word,    // word to attenuator core
  output var  logic                     o_fast_active,    // fast word is applied
  output var  logic                     o_fast_enable,    // setup enable bit
  output var  logic                     o_write_pulse,    // one cycle per accepted write
  output var  logic                     o_write_dropped   // one cycle per full frame that hits no register
);
  import ssa_pkg::*;

  // reset release through two flops
  logic rst_meta;
  logic rst_n;

  // assertion is asynchronous, release lines up with the clock
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // pin sampling
  wire  [SYNC_W-1:0] raw_pins;
  logic [SYNC_W-1:0] pin_level;
  logic [SYNC_W-1:0] pin_prev;

  assign raw_pins[LANE_CLK]    = i_ser_clk;
  assign raw_pins[LANE_DATA]   = i_ser_data;
  assign raw_pins[LANE_STROBE] = i_latch_strobe;
  assign raw_pins[LANE_FAST]   = i_fast_select_pin;

  ssa_sync u_sync (
    .i_clk   (i_ref_clk),
    .i_rst_n (rst_n),
    .i_pins  (raw_pins),
    .o_level (pin_level)
  );

  // previous filtered levels for edge finding
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev <= SYNC_RST;
    end else begin
      pin_prev <= pin_level;
    end
  end

  // edges and levels of the filtered link signals
  wire clk_rise    = pin_level[LANE_CLK] & ~pin_prev[LANE_CLK];
  wire strobe_rise = pin_level[LANE_STROBE] & ~pin_prev[LANE_STROBE];
  wire strobe_fall = ~pin_level[LANE_STROBE] & pin_prev[LANE_STROBE];
  wire strobe_low  = ~pin_level[LANE_STROBE];
  wire ser_bit     = pin_level[LANE_DATA];
  wire fast_pin    = pin_level[LANE_FAST];

  // frame shifter
  ssa_state_e            state;
  ssa_state_e            next_state;
  logic [FRAME_BITS-1:0] shift_reg;
  logic [CNT_W-1:0]      bit_cnt;

  // bits are only taken while the strobe is low
  wire take_bit  = clk_rise & strobe_low & (state == SSA_SHIFT);
  wire cnt_full  = (bit_cnt == CNT_FULL);
  wire commit    = (state == SSA_ARMED) & strobe_fall;

  // lsb first: new bit enters at the top, data byte settles low
  wire [FRAME_BITS-1:0] next_shift = {ser_bit, shift_reg[FRAME_BITS-1:1]};

  // counter saturates so extra clocks keep the last 16 bits
  wire [CNT_W-1:0] next_cnt_inc = cnt_full ? bit_cnt : bit_cnt + 5'h01;

  // sequencer: low strobe opens, rise arms, fall commits
  always_comb begin
    next_state = state;
    case (state)
      SSA_IDLE: begin
        if (strobe_low) begin
          next_state = SSA_SHIFT;
        end
      end
      SSA_SHIFT: begin
        if (strobe_rise) begin
          next_state = cnt_full ? SSA_ARMED : SSA_IDLE;
        end
      end
      SSA_ARMED: begin
        if (strobe_fall) begin
          next_state = SSA_SHIFT;
        end
      end
      default: begin
        next_state = SSA_IDLE;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SSA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // shift register and bit count; the count clears outside the shift state
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
      bit_cnt   <= '0;
    end else if (take_bit) begin
      shift_reg <= next_shift;
      bit_cnt   <= next_cnt_inc;
    end else if (state != SSA_SHIFT) begin
      bit_cnt <= '0;
    end
  end

  // address decode
  wire [REG_W-1:0] frame_data = shift_reg[DATA_MSB:DATA_LSB];
  wire [2:0]       frame_chip = shift_reg[CHIP_MSB:CHIP_LSB];
  wire [3:0]       frame_reg  = shift_reg[REG_MSB:REG_LSB];

  // one register hit, used for each of the three targets
  function automatic logic reg_hit(input logic [2:0] chip,
                                   input logic [3:0] addr,
                                   input logic [3:0] target);
    reg_hit = (chip == CHIP_ADDR) && (addr == target);
  endfunction : reg_hit

  wire hit_primary = commit & reg_hit(frame_chip, frame_reg, ADDR_PRIMARY);
  wire hit_setup   = commit & reg_hit(frame_chip, frame_reg, ADDR_SETUP);
  wire hit_fast    = commit & reg_hit(frame_chip, frame_reg, ADDR_FAST);
  wire hit_any     = hit_primary | hit_setup | hit_fast;
  // any other chip or register address falls through untouched
  wire miss        = commit & ~hit_any;

  // register file, write only
  logic [REG_W-1:0] primary_attenuation;
  logic [REG_W-1:0] feature_setup;
  logic [REG_W-1:0] fast_select_attenuation;

  // power-on value puts the primary word at full attenuation
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_attenuation <= PRIMARY_RST;
    end else if (hit_primary) begin
      primary_attenuation <= frame_data;
    end
  end

  // setup clears on power-on, so fast select starts disabled
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      feature_setup <= SETUP_RST;
    end else if (hit_setup) begin
      feature_setup <= frame_data;
    end
  end

  // fast word also starts at full attenuation until written
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_select_attenuation <= FAST_RST;
    end else if (hit_fast) begin
      fast_select_attenuation <= frame_data;
    end
  end

  // core word selection
  // pointer bit is stored but only the register source is supported
  wire fast_en  = feature_setup[SETUP_EN_BIT];
  wire use_fast = fast_en & fast_pin;
  // bit 7 is unused; the low 7 bits are the 0.25 dB cell count
  wire [ATT_W-1:0] primary_word = primary_attenuation[ATT_W-1:0];
  wire [ATT_W-1:0] fast_word    = fast_select_attenuation[ATT_W-1:0];
  // pin high and enabled picks the fast word, else the primary word
  wire [ATT_W-1:0] next_atten   = use_fast ? fast_word : primary_word;

  // core word registered; a primary write shows two cycles after commit
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_atten_word <= ATT_MAX;
    end else begin
      o_atten_word <= next_atten;
    end
  end

  // source status, registered alongside the word so they move together
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_fast_active <= 1'b0;
      o_fast_enable <= 1'b0;
    end else begin
      o_fast_active <= use_fast;
      o_fast_enable <= fast_en;
    end
  end

  // write status pulses, one cycle per committed frame
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_write_pulse   <= 1'b0;
      o_write_dropped <= 1'b0;
    end else begin
      o_write_pulse   <= hit_any;
      o_write_dropped <= miss;
    end
  end

endmodule : ssa_top

`default_nettype wire

//--- tb/ssa_top_asserts.sv
// port checker for the serial attenuator control block
// assumes a bind onto ssa_top and pins driven away from the ref edge
`default_nettype none

module ssa_chk (
  input wire logic                     i_ref_clk,         // ref clock
  input wire logic                     i_nrst,            // reset, active low
  input wire logic                     i_fast_select_pin, // fast pin
  input wire logic [ssa_pkg::ATT_W-1:0] o_atten_word,     // core word
  input wire logic                     o_fast_active,     // fast applied
  input wire logic                     o_fast_enable,     // enable bit
  input wire logic                     o_write_pulse,     // write done
  input wire logic                     o_write_dropped    // frame ignored
);
  timeunit 1ns;
  timeprecision 1ns;
  import ssa_pkg::*;
  // one domain, so clock and reset are given once
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  property p_rst; $rose(i_nrst) |-> o_atten_word == 7'h7F && !o_fast_enable; endproperty
  a_rst: assert property (p_rst) else $error("reset word wrong");
  property p_gate; o_fast_active |-> o_fast_enable; endproperty
  a_gate: assert property (p_gate) else $error("fast word without enable");
  property p_low; !i_fast_select_pin [*8] |-> !o_fast_active; endproperty
  a_low: assert property (p_low) else $error("fast word with pin low");
  property p_high; (o_fast_enable && i_fast_select_pin) [*8] |-> o_fast_active; endproperty
  a_high: assert property (p_high) else $error("fast word not applied");
  property p_pulse; o_write_pulse |=> !o_write_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse too long");
  property p_excl; !(o_write_pulse && o_write_dropped); endproperty
  a_excl: assert property (p_excl) else $error("write both taken and dropped");
  // the word moves one cycle after a write pulse, or together with a source switch
  property p_cause;
    $changed(o_atten_word) |-> $past(o_write_pulse) || $changed(o_fast_active);
  endproperty
  a_cause: assert property (p_cause) else $error("word changed without cause");
  // a dropped frame would show its effect one cycle after the pulse
  property p_drop;
    o_write_dropped |=> $stable(o_atten_word) && $stable(o_fast_enable);
  endproperty
  a_drop: assert property (p_drop) else $error("dropped frame changed state");
  property p_en; $changed(o_fast_enable) |-> $past(o_write_pulse); endproperty
  a_en: assert property (p_en) else $error("enable moved without write");
endmodule : ssa_chk

bind ssa_top ssa_chk i_chk (.i_ref_clk, .i_nrst, .i_fast_select_pin, .o_atten_word,
  .o_fast_active, .o_fast_enable, .o_write_pulse, .o_write_dropped);

`default_nettype wire

//--- tb/ssa_ctrl_model.sv
// serial controller model: clock, data and strobe of the write link
// assumes the bench clock is 50 ns; link clock runs 400 ns, only in frames
`default_nettype none

module ssa_ctrl_model (
  input  wire logic i_clk,    // bench clock
  output var  logic o_sclk,   // serial clock, idles low
  output var  logic o_sdata,  // serial data
  output var  logic o_strobe  // latch strobe, high until the first frame, left low after each
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_strobe = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge i_clk);
  endtask : hold

  // n below 16 sends a cut-short frame on purpose
  task automatic send(input logic [15:0] f, input int n);
    o_strobe = 1'b0;
    hold(4);
    for (int k = 0; k < n; k++) begin
      o_sdata = f[k];
      hold(4);
      o_sclk = 1'b1;
      hold(4);
      o_sclk = 1'b0;
    end
    // stale data would hide a late sample
    o_sdata = ~o_sdata;
    o_strobe = 1'b1;
    hold(4);
    o_strobe = 1'b0;
    hold(4);
  endtask : send
endmodule : ssa_ctrl_model

`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for ssa_top driven by the serial controller model
// assumes the checker is bound from its own file
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ssa_pkg::*;
  logic             clk = 1'b0;
  logic             nrst = 1'b0;
  logic             fsp = 1'b0;
  logic             sclk, sdat, strb;
  logic [ATT_W-1:0] att;
  logic             fa, fe, wp, wd;
  int               fail_count = 0, total_checks = 0, np = 0, nd = 0;

  always #25 clk = ~clk;
  // tally the one-cycle status pulses mid-cycle, where they are settled
  always @(negedge clk) begin
    if (wp === 1'b1) np++;
    if (wd === 1'b1) nd++;
  end

  ssa_ctrl_model i_ctrl (.i_clk(clk), .o_sclk(sclk), .o_sdata(sdat), .o_strobe(strb));
  ssa_top i_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_ser_clk(sclk), .i_ser_data(sdat),
    .i_latch_strobe(strb), .i_fast_select_pin(fsp), .o_atten_word(att),
    .o_fast_active(fa), .o_fast_enable(fe), .o_write_pulse(wp), .o_write_dropped(wd));

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  function automatic logic [15:0] frm(logic [3:0] r, logic [2:0] c, logic [7:0] d);
    return {r, 1'b0, c, d};
  endfunction : frm

  // the answer lands about six edges after the strobe falls
  task automatic wr(input logic [15:0] f, input int n);
    i_ctrl.send(f, n);
    repeat (20) @(negedge clk);
  endtask : wr

  task automatic t_primary;
    chk("word", 8'(att), 8'h7F);
    chk("enable", 8'(fe), 8'h00);
    wr(frm(4'h0, 3'h0, 8'hB5), 16);
    chk("word", 8'(att), 8'h35);
    wr(frm(4'h0, 3'h0, 8'h00), 16);
    chk("word", 8'(att), 8'h00);
    chk("pulses", 8'(np), 8'h02);
    $display("primary test done");
  endtask : t_primary

  task automatic t_fast;
    fsp = 1'b1;
    repeat (12) @(negedge clk);
    chk("word", 8'(att), 8'h00);
    wr(frm(4'h1, 3'h0, 8'h02), 16);
    chk("enable", 8'(fe), 8'h01);
    chk("word", 8'(att), 8'h7F);
    wr(frm(4'h2, 3'h0, 8'h91), 16);
    chk("word", 8'(att), 8'h11);
    chk("active", 8'(fa), 8'h01);
    fsp = 1'b0;
    repeat (12) @(negedge clk);
    chk("word", 8'(att), 8'h00);
    chk("active", 8'(fa), 8'h00);
    $display("fast test done");
  endtask : t_fast

  task automatic t_bad;
    wr(frm(4'h3, 3'h0, 8'h55), 16);
    wr(frm(4'h0, 3'h1, 8'h55), 16);
    chk("word", 8'(att), 8'h00);
    chk("drops", 8'(nd), 8'h02);
    wr(frm(4'h0, 3'h0, 8'h55), 10);
    chk("word", 8'(att), 8'h00);
    chk("pulses", 8'(np), 8'h04);
    wr(frm(4'h1, 3'h0, 8'h00), 16);
    chk("enable", 8'(fe), 8'h00);
    $display("bad frame test done");
  endtask : t_bad

  // reset in mid-run: both words must return to full attenuation
  task automatic t_reset;
    nrst = 1'b0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (10) @(negedge clk);
    chk("word", 8'(att), 8'h7F);
    chk("enable", 8'(fe), 8'h00);
    fsp = 1'b1;
    wr(frm(4'h1, 3'h0, 8'h02), 16);
    chk("word", 8'(att), 8'h7F);
    chk("active", 8'(fa), 8'h01);
    fsp = 1'b0;
    repeat (12) @(negedge clk);
    chk("word", 8'(att), 8'h7F);
    $display("reset test done");
  endtask : t_reset

  task automatic results;
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (10) @(negedge clk);
    t_primary();
    t_fast();
    t_bad();
    t_reset();
    results();
  end

  // a hang counts as a failure
  initial begin
    #2000000;
    fail_count++;
    results();
  end
endmodule : testbench

`default_nettype wire
